// *** core/cfd_filter.v ***
// Purpose: consecutive-sample fault filter for one monitored condition
// Assumes: sample is a one-cycle strobe, fail valid with it
// Notes: fires on every failing sample once the run reaches the limit
`timescale 1ns/1ps
module cfd_filter (
  input wire pclk,
  input wire presetn,
  input wire clear,
  input wire sample,
  input wire fail,
  input wire [7:0] limit,
  output reg fire
);
  reg [7:0] count;
  wire [7:0] count_inc;
  assign count_inc = count + 8'h01;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 8'h00;
      fire <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (clear) begin
        count <= 8'h00;
      end else if (sample) begin
        if (!fail) begin
          count <= 8'h00;
        end else if (count_inc >= limit) begin
          // saturate so a long fault run cannot wrap and re-arm
          count <= limit;
          fire <= 1'b1;
        end else begin
          count <= count_inc;
        end
      end
    end
  end
endmodule

// *** core/cfd_regs.vh ***
// Purpose: register map, fields and reset values of the fault diagnostics
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes: definitions only
`ifndef CFD_REGS_VH
`define CFD_REGS_VH

`define CFD_ADDR_W 8
`define CFD_OFF_STATUS 8'h00
`define CFD_OFF_UV_FAULT 8'h04
`define CFD_OFF_OW_FAULT 8'h08
`define CFD_OFF_OT_FAULT 8'h0C
`define CFD_OFF_FAULT_SETUP 8'h10
`define CFD_OFF_CELL_SETUP 8'h14
`define CFD_OFF_DEV_SETUP 8'h18
`define CFD_OFF_UV_LIMIT 8'h1C
`define CFD_OFF_TEMP_LIMIT 8'h20
`define CFD_OFF_COMMAND 8'h24

`define CFD_NCELL 12
`define CFD_NWIRE 13
`define CFD_NTEMP 4
`define CFD_CODE_W 14
`define CFD_CNT_W 8

// summary status bit positions
`define CFD_ST_UV 0
`define CFD_ST_OPEN 1
`define CFD_ST_OW 2
`define CFD_ST_OT 3
`define CFD_ST_W 4

// fault setup fields
`define CFD_FILT_LSB 0
`define CFD_FILT_MSB 2
`define CFD_TEN_LSB 4
`define CFD_TEN_MSB 7
`define CFD_FILT_RST 3'h3
`define CFD_TEN_RST 4'h0

`define CFD_CELL_RST 12'h000
`define CFD_SCAN_CURRENT_SELECT_RST 1'b1
`define CFD_SCAN_CURRENT_SELECT_BIT 0
`define CFD_UV_LIM_RST 14'h0000
`define CFD_TEMP_LIM_RST 14'h0000
`define CFD_CMD_WIRE 0
`define CFD_FIRST_CFG_WIRE 2

`endif

// *** core/cfd_temp_check.v ***
// Purpose: over-temperature compare of the external inputs, unfiltered
// Assumes: codes valid in the cycle of the scan strobe
// Notes: hot means input voltage below the limit (falling with heat)
`timescale 1ns/1ps
`include "cfd_regs.vh"
module cfd_temp_check (
  input wire pclk,
  input wire presetn,
  input wire scan,
  input wire [`CFD_NTEMP*`CFD_CODE_W-1:0] codes,
  input wire [`CFD_NTEMP-1:0] enable,
  input wire [`CFD_CODE_W-1:0] limit,
  output reg [`CFD_NTEMP-1:0] hits
);
  reg [`CFD_NTEMP-1:0] next_hits;
  integer i;

  always @* begin
    next_hits = {`CFD_NTEMP{1'b0}};
    for (i = 0; i < `CFD_NTEMP; i = i + 1) begin
      next_hits[i] = enable[i] & scan &
        (codes[i*`CFD_CODE_W +: `CFD_CODE_W] < limit); // see RULE17 RULE18
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hits <= {`CFD_NTEMP{1'b0}};
    end else begin
      hits <= next_hits;
    end
  end
endmodule

// *** core/cfd_top.v ***
// Purpose: cell fault diagnostics with an APB register file
// Assumes: scan results come from logic on pclk, no synchroniser needed
// Notes: detail and summary faults are write-one-to-clear, set wins
//
// Operation
// RULE1: filter count field resets to eight-sample code
// RULE2: cell config bit one means no cell
// RULE3: unpopulated cells skip the undervoltage compare
// RULE4: undervoltage flagged after consecutive failing scans
// RULE5: fault arriving at zero summary is sent out
// RULE6: host reads detail only when summary shows fault
// RULE7: host clears undervoltage detail, then summary
// RULE8: changing filter count field resets all filters
// RULE9: passing undervoltage compare clears that cell filter
// RULE10: open supply/ground flagged after consecutive scans
// RULE11: open filter cleared when connections found closed
// RULE12: scan current select one means high current
// RULE13: inputs two to twelve maskable, zero/one always
// RULE14: host waits for wire scan before reading
// RULE15: host clears open-wire detail, then summary
// RULE16: temperature limit is a 14-bit code
// RULE17: temperature enable bit includes input when one
// RULE18: over-temperature set at once, no filtering
// RULE19: undervoltage limit code, 1FFF is 5 volts
// RULE20: one filter and fault bit per cell
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "cfd_regs.vh"
module cfd_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire volt_scan_done,
  input wire [`CFD_NCELL*`CFD_CODE_W-1:0] cell_codes,
  input wire supply_open,
  output reg scan_current_select,
  output reg wire_scan_start,
  input wire wire_scan_done,
  input wire [`CFD_NWIRE-1:0] wire_open,
  output reg [`CFD_NWIRE-1:0] wire_test_enable,
  input wire temp_scan_done,
  input wire [`CFD_NTEMP*`CFD_CODE_W-1:0] temp_codes,
  output reg fault_report_valid,
  output reg [31:0] fault_report_data
);
  reg [`CFD_ST_W-1:0] fault_status;
  reg [`CFD_NCELL-1:0] uv_fault;
  reg [`CFD_NWIRE-1:0] ow_fault;
  reg [`CFD_NTEMP-1:0] ot_fault;
  reg [2:0] fault_filter_count_field;
  reg [`CFD_NTEMP-1:0] temp_test_enable;
  reg [`CFD_NCELL-1:0] cell_setup;
  reg [`CFD_CODE_W-1:0] uv_limit;
  reg [`CFD_CODE_W-1:0] temp_limit;
  reg wire_busy;

  reg [`CFD_ST_W-1:0] next_status;
  reg [`CFD_NCELL-1:0] next_uv;
  reg [`CFD_NWIRE-1:0] next_ow;
  reg [`CFD_NTEMP-1:0] next_ot;
  reg [31:0] next_rdata;
  reg next_err;

  wire access;
  wire wr_done;
  wire [`CFD_ADDR_W-1:0] addr;
  wire [7:0] fault_filter_count;
  wire filter_reset;
  wire [`CFD_NCELL-1:0] uv_fire;
  wire open_fire;
  wire [`CFD_NTEMP-1:0] ot_hits;
  wire [`CFD_NWIRE-1:0] ow_hits;

  // pready rises one cycle into the access phase; data registered with it
  assign access = psel & penable & ~pready;
  assign wr_done = psel & penable & pready & pwrite;
  assign addr = paddr[`CFD_ADDR_W-1:0];

  // functions see only their arguments, so the continuous assigns that use
  // them stay sensitive to every bus signal involved
  function is_reg;
    input [31:0] a;
    input [`CFD_ADDR_W-1:0] off;
    begin
      is_reg = (a == {{(32-`CFD_ADDR_W){1'b0}}, off});
    end
  endfunction

  function [31:0] w1c_mask;
    input hit;
    input [31:0] data;
    begin
      w1c_mask = hit ? data : 32'h00000000;
    end
  endfunction

  // write-one-to-clear masks; each use cuts its own flag field
  wire [31:0] clr_status;
  wire [31:0] clr_uv;
  wire [31:0] clr_ow;
  wire [31:0] clr_ot;
  assign clr_status = w1c_mask(wr_done && is_reg(paddr, `CFD_OFF_STATUS),
    pwdata);
  assign clr_uv = w1c_mask(wr_done && is_reg(paddr, `CFD_OFF_UV_FAULT),
    pwdata);
  assign clr_ow = w1c_mask(wr_done && is_reg(paddr, `CFD_OFF_OW_FAULT),
    pwdata);
  assign clr_ot = w1c_mask(wr_done && is_reg(paddr, `CFD_OFF_OT_FAULT),
    pwdata);

  // code n selects 2**n samples, so 3'h3 gives eight
  assign fault_filter_count = 8'h01 << fault_filter_count_field;
  assign filter_reset = wr_done && is_reg(paddr, `CFD_OFF_FAULT_SETUP) &&
    (pwdata[`CFD_FILT_MSB:`CFD_FILT_LSB] !=
     fault_filter_count_field); // see RULE8

  genvar g;
  generate
    for (g = 0; g < `CFD_NCELL; g = g + 1) begin : g_cell
      wire below;
      assign below = (cell_codes[g*`CFD_CODE_W +: `CFD_CODE_W] <
        uv_limit); // see RULE19
      // unpopulated cells keep their filter cleared, never compared
      cfd_filter u_filt (
        .pclk(pclk),
        .presetn(presetn),
        .clear(filter_reset | cell_setup[g]), // see RULE3 RULE2
        .sample(volt_scan_done),
        .fail(below), // see RULE9
        .limit(fault_filter_count),
        .fire(uv_fire[g]) // see RULE4 RULE20
      );
    end
  endgenerate

  cfd_filter u_open_filt (
    .pclk(pclk),
    .presetn(presetn),
    .clear(filter_reset),
    .sample(volt_scan_done),
    .fail(supply_open), // see RULE10 RULE11
    .limit(fault_filter_count),
    .fire(open_fire)
  );

  // temperature faults skip the filter: one hot scan latches
  cfd_temp_check u_temp (
    .pclk(pclk),
    .presetn(presetn),
    .scan(temp_scan_done),
    .codes(temp_codes),
    .enable(temp_test_enable),
    .limit(temp_limit),
    .hits(ot_hits)
  );

  // a done strobe with no scan running is dropped
  assign ow_hits = (wire_scan_done & wire_busy) ?
    (wire_open & wire_test_enable) : {`CFD_NWIRE{1'b0}};

  // detail and summary flags: a same-cycle set beats the clear
  always @* begin
    next_uv = (uv_fault &
      ~clr_uv[`CFD_NCELL-1:0]) | uv_fire; // see RULE20
    next_ow = (ow_fault &
      ~clr_ow[`CFD_NWIRE-1:0]) | ow_hits;
    next_ot = (ot_fault &
      ~clr_ot[`CFD_NTEMP-1:0]) | ot_hits; // see RULE18
    next_status = fault_status & ~clr_status[`CFD_ST_W-1:0];
    next_status[`CFD_ST_UV] = next_status[`CFD_ST_UV] | (|uv_fire);
    next_status[`CFD_ST_OPEN] = next_status[`CFD_ST_OPEN] | open_fire;
    next_status[`CFD_ST_OW] = next_status[`CFD_ST_OW] | (|ow_hits);
    next_status[`CFD_ST_OT] = next_status[`CFD_ST_OT] | (|ot_hits);
  end

  always @* begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    case (addr)
      `CFD_OFF_STATUS: next_rdata[`CFD_ST_W-1:0] = fault_status;
      `CFD_OFF_UV_FAULT: next_rdata[`CFD_NCELL-1:0] = uv_fault;
      `CFD_OFF_OW_FAULT: next_rdata[`CFD_NWIRE-1:0] = ow_fault;
      `CFD_OFF_OT_FAULT: next_rdata[`CFD_NTEMP-1:0] = ot_fault;
      `CFD_OFF_FAULT_SETUP: begin
        next_rdata[`CFD_FILT_MSB:`CFD_FILT_LSB] = fault_filter_count_field;
        next_rdata[`CFD_TEN_MSB:`CFD_TEN_LSB] = temp_test_enable;
      end
      `CFD_OFF_CELL_SETUP: next_rdata[`CFD_NCELL-1:0] = cell_setup;
      `CFD_OFF_DEV_SETUP: next_rdata[`CFD_SCAN_CURRENT_SELECT_BIT] = scan_current_select;
      `CFD_OFF_UV_LIMIT: next_rdata[`CFD_CODE_W-1:0] = uv_limit;
      `CFD_OFF_TEMP_LIMIT: next_rdata[`CFD_CODE_W-1:0] = temp_limit;
      `CFD_OFF_COMMAND: next_rdata[`CFD_CMD_WIRE] = wire_busy;
      default: next_err = 1'b1;
    endcase
    if (paddr[31:`CFD_ADDR_W] != 24'h000000) begin
      next_rdata = 32'h00000000;
      next_err = 1'b1;
    end
  end

  // apb answer; prdata holds until the next access, writes answer zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access;
      if (access) begin
        pslverr <= next_err;
        prdata <= pwrite ? 32'h00000000 : next_rdata;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_filter_count_field <= `CFD_FILT_RST; // see RULE1
      temp_test_enable <= `CFD_TEN_RST;
      cell_setup <= `CFD_CELL_RST;
      scan_current_select <= `CFD_SCAN_CURRENT_SELECT_RST;
      uv_limit <= `CFD_UV_LIM_RST;
      temp_limit <= `CFD_TEMP_LIM_RST;
    end else if (wr_done) begin
      if (is_reg(paddr, `CFD_OFF_FAULT_SETUP)) begin
        fault_filter_count_field <= pwdata[`CFD_FILT_MSB:`CFD_FILT_LSB];
        temp_test_enable <= pwdata[`CFD_TEN_MSB:`CFD_TEN_LSB]; // see RULE17
      end
      if (is_reg(paddr, `CFD_OFF_CELL_SETUP)) begin
        cell_setup <= pwdata[`CFD_NCELL-1:0]; // see RULE2
      end
      if (is_reg(paddr, `CFD_OFF_DEV_SETUP)) begin
        scan_current_select <= pwdata[`CFD_SCAN_CURRENT_SELECT_BIT]; // see RULE12
      end
      if (is_reg(paddr, `CFD_OFF_UV_LIMIT)) begin
        uv_limit <= pwdata[`CFD_CODE_W-1:0]; // see RULE19
      end
      if (is_reg(paddr, `CFD_OFF_TEMP_LIMIT)) begin
        temp_limit <= pwdata[`CFD_CODE_W-1:0]; // see RULE16
      end
    end
  end

  // wire-scan mask: inputs zero and one are never masked; wire k
  // answers to cell bit k-1
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wire_test_enable <= {`CFD_NWIRE{1'b1}};
    end else begin
      wire_test_enable <= {~cell_setup[`CFD_NCELL-1:`CFD_FIRST_CFG_WIRE-1],
        {`CFD_FIRST_CFG_WIRE{1'b1}}}; // see RULE13
    end
  end

  // wire scan command; a start while busy is ignored
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wire_busy <= 1'b0;
      wire_scan_start <= 1'b0;
    end else begin
      wire_scan_start <= 1'b0;
      if (wire_busy && wire_scan_done) begin
        wire_busy <= 1'b0; // see RULE14
      end else if (!wire_busy && wr_done &&
                   is_reg(paddr, `CFD_OFF_COMMAND) &&
                   pwdata[`CFD_CMD_WIRE]) begin
        wire_busy <= 1'b1;
        wire_scan_start <= 1'b1;
      end
    end
  end

  // summary goes from zero to nonzero at the coming edge
  wire report_now;
  assign report_now = (fault_status == {`CFD_ST_W{1'b0}}) &&
    (next_status != {`CFD_ST_W{1'b0}}); // see RULE5

  // fault latches and unsolicited summary report
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_status <= {`CFD_ST_W{1'b0}};
      uv_fault <= {`CFD_NCELL{1'b0}};
      ow_fault <= {`CFD_NWIRE{1'b0}};
      ot_fault <= {`CFD_NTEMP{1'b0}};
      fault_report_valid <= 1'b0;
      fault_report_data <= 32'h00000000;
    end else begin
      fault_status <= next_status; // see RULE7 RULE15 RULE6
      uv_fault <= next_uv;
      ow_fault <= next_ow;
      ot_fault <= next_ot;
      // only a zero summary triggers: later faults wait for a host read
      fault_report_valid <= report_now; // see RULE5
      if (report_now) begin
        fault_report_data <= {{(32-`CFD_ST_W){1'b0}}, next_status};
      end
    end
  end
endmodule

// *** sim/cfd_afe_model.sv ***
// Purpose: scan front end stand-in driving scan results
// Assumes: requests are one-cycle pulses on pclk
// Notes: data lines show the inverse outside their done strobe
`timescale 1ns/1ps
module cfd_afe_model (
  input wire pclk,
  input wire v_req,
  input wire t_req,
  input wire [167:0] v_want,
  input wire s_want,
  input wire [55:0] t_want,
  input wire [12:0] w_want,
  input wire wire_scan_start,
  output reg volt_scan_done = 1'b0,
  output wire [167:0] cell_codes,
  output wire supply_open,
  output reg temp_scan_done = 1'b0,
  output wire [55:0] temp_codes,
  output reg wire_scan_done = 1'b0,
  output wire [12:0] wire_open
);
  reg [3:0] w_cnt = 4'h0;
  assign cell_codes = volt_scan_done ? v_want : ~v_want;
  assign supply_open = volt_scan_done ? s_want : ~s_want;
  assign temp_codes = temp_scan_done ? t_want : ~t_want;
  assign wire_open = wire_scan_done ? w_want : ~w_want;
  always @(posedge pclk) begin
    volt_scan_done <= v_req;
    temp_scan_done <= t_req;
    wire_scan_done <= (w_cnt == 4'h1);
    // slow answer so the busy flag can be seen by the host
    if (wire_scan_start)
      w_cnt <= 4'h9;
    else if (w_cnt != 4'h0)
      w_cnt <= w_cnt - 4'h1;
  end
endmodule

// *** sim/cfd_chk.sv ***
// Purpose: port-level checks on the fault diagnostics
// Assumes: one clock, async active-low reset
// Notes: bound to cfd_top below the module
`timescale 1ns/1ps
module cfd_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wire_scan_start,
  input wire logic [12:0] wire_test_enable,
  input wire logic fault_report_valid,
  input wire logic [31:0] fault_report_data
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_take: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_report_pulse: assert property (
    fault_report_valid |=> !fault_report_valid)
    else $error("report held");
  a_report_nonzero: assert property (
    fault_report_valid |->
    fault_report_data != 32'h0 && fault_report_data[31:4] == 28'h0)
    else $error("report data bad");
  a_low_wires_on: assert property (wire_test_enable[1:0] == 2'h3)
    else $error("low wires masked");
  a_start_pulse: assert property (wire_scan_start |=> !wire_scan_start)
    else $error("start held");
  a_start_cause: assert property (wire_scan_start |-> $past(pready && psel
    && pwrite && paddr == 32'h24 && pwdata[0]))
    else $error("start without command");
  a_mask_follows_cells: assert property (
    $changed(wire_test_enable) |->
    $past(psel && penable && pready && pwrite && paddr == 32'h14, 2) &&
    wire_test_enable[12:2] == ~$past(pwdata[11:1], 2))
    else $error("wire mask not from cell setup");
endmodule
bind cfd_top cfd_chk i_cfd_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .wire_scan_start, .wire_test_enable,
  .fault_report_valid, .fault_report_data);

// *** sim/cfd_top_tb_top.sv ***
// Purpose: self-checking bench for the fault diagnostics
// Assumes: APB master here, scan front end in cfd_afe_model
// Notes: one task per scenario
`timescale 1ns/1ps
`include "cfd_regs.vh"
module cfd_top_tb_top;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  reg pwrite = 1'b0, v_req = 1'b0, t_req = 1'b0, s_want = 1'b0, er;
  reg [31:0] paddr = 32'h0, pwdata = 32'h0, rd, rep;
  reg [167:0] v_want = {12{14'h1800}};
  reg [55:0] t_want = {14'h1000, 14'h3000, 14'h1000, 14'h1000};
  reg [12:0] w_want = 13'h1FFF;
  wire [31:0] prdata, fault_report_data;
  wire [167:0] cell_codes;
  wire [55:0] temp_codes;
  wire [12:0] wire_open, wire_test_enable;
  wire pready, pslverr, volt_scan_done, supply_open, scan_current_select;
  wire wire_scan_start, wire_scan_done, temp_scan_done, fault_report_valid;
  int n_fail = 0, n_checks = 0, n_rep = 0, cyc = 0, n_start = 0;
  cfd_top i_cfd_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .volt_scan_done, .cell_codes,
    .supply_open, .scan_current_select, .wire_scan_start, .wire_scan_done,
    .wire_open, .wire_test_enable, .temp_scan_done, .temp_codes,
    .fault_report_valid, .fault_report_data);
  cfd_afe_model i_cfd_afe_model (.pclk, .v_req, .t_req, .v_want, .s_want,
    .t_want, .w_want, .wire_scan_start, .volt_scan_done, .cell_codes,
    .supply_open, .temp_scan_done, .temp_codes, .wire_scan_done,
    .wire_open);
  always #12.5 pclk = ~pclk;
  task close_out;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (fault_report_valid === 1'b1) begin
      n_rep++;
      rep = fault_report_data;
    end
    if (wire_scan_start === 1'b1)
      n_start++;
    if (cyc == 5000) begin
      n_fail++;
      close_out;
    end
  end
  task chk(input string n, input [31:0] e, input [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input string n, input [7:0] a, input [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task scan(input t, input int n);
    repeat (n) begin
      @(posedge pclk);
      if (t) t_req <= 1'b1;
      else v_req <= 1'b1;
      @(posedge pclk);
      t_req <= 1'b0;
      v_req <= 1'b0;
    end
    repeat (4) @(posedge pclk);
  endtask
  task t_reset;
    rdc("filter", `CFD_OFF_FAULT_SETUP, 32'h3);
    chk("iscan", 32'h1, {31'h0, scan_current_select});
    apb(1'b1, `CFD_OFF_DEV_SETUP, 32'h0);
    @(posedge pclk);
    chk("iscan", 32'h0, {31'h0, scan_current_select});
    apb(1'b1, `CFD_OFF_TEMP_LIMIT, 32'hFFFFFFFF);
    rdc("tlim", `CFD_OFF_TEMP_LIMIT, 32'h3FFF);
    apb(1'b1, `CFD_OFF_UV_LIMIT, 32'h1FFF);
    rdc("uvlim", `CFD_OFF_UV_LIMIT, 32'h1FFF);
    apb(1'b0, 8'h28, 32'h0);
    chk("err", 32'h1, {31'h0, er});
  endtask
  task t_uv;
    apb(1'b1, `CFD_OFF_CELL_SETUP, 32'h2);
    apb(1'b1, `CFD_OFF_UV_LIMIT, 32'h1000);
    v_want[27:0] <= {14'h0800, 14'h0800};
    scan(1'b0, 7);
    rdc("uv7", `CFD_OFF_UV_FAULT, 32'h0);
    v_want[13:0] <= 14'h1800;
    scan(1'b0, 1);
    v_want[13:0] <= 14'h0800;
    scan(1'b0, 7);
    rdc("uvpass", `CFD_OFF_UV_FAULT, 32'h0);
    apb(1'b1, `CFD_OFF_FAULT_SETUP, 32'h2);
    apb(1'b1, `CFD_OFF_FAULT_SETUP, 32'h3);
    scan(1'b0, 7);
    rdc("uvfilt", `CFD_OFF_UV_FAULT, 32'h0);
    scan(1'b0, 1);
    rdc("uv8", `CFD_OFF_UV_FAULT, 32'h1);
    rdc("st", `CFD_OFF_STATUS, 32'h1);
    chk("rep", 32'h1, rep);
    v_want <= {12{14'h1800}};
    apb(1'b1, `CFD_OFF_UV_FAULT, 32'h1);
    apb(1'b1, `CFD_OFF_STATUS, 32'h1);
    rdc("st", `CFD_OFF_STATUS, 32'h0);
  endtask
  task t_open;
    s_want <= 1'b1;
    scan(1'b0, 4);
    s_want <= 1'b0;
    scan(1'b0, 1);
    s_want <= 1'b1;
    scan(1'b0, 7);
    rdc("op7", `CFD_OFF_STATUS, 32'h0);
    scan(1'b0, 1);
    s_want <= 1'b0;
    rdc("op8", `CFD_OFF_STATUS, 32'h2);
    chk("rep", 32'h2, rep);
  endtask
  task t_wire;
    apb(1'b1, `CFD_OFF_CELL_SETUP, 32'h3);
    repeat (2) @(posedge pclk);
    chk("wten", 32'h1FFB, {19'h0, wire_test_enable});
    apb(1'b1, `CFD_OFF_COMMAND, 32'h1);
    rdc("busy", `CFD_OFF_COMMAND, 32'h1);
    do apb(1'b0, `CFD_OFF_COMMAND, 32'h0); while (rd[0] !== 1'b0);
    chk("start", 32'h1, n_start);
    rdc("ow", `CFD_OFF_OW_FAULT, 32'h1FFB);
    rdc("st", `CFD_OFF_STATUS, 32'h6);
    chk("nrep", 32'h2, n_rep);
    apb(1'b1, `CFD_OFF_OW_FAULT, 32'h1FFF);
    apb(1'b1, `CFD_OFF_STATUS, 32'hF);
    rdc("st", `CFD_OFF_STATUS, 32'h0);
  endtask
  task t_temp;
    apb(1'b1, `CFD_OFF_TEMP_LIMIT, 32'h2000);
    apb(1'b1, `CFD_OFF_FAULT_SETUP, 32'h53);
    scan(1'b1, 1);
    rdc("ot", `CFD_OFF_OT_FAULT, 32'h1);
    chk("rep", 32'h8, rep);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_uv;
    t_open;
    t_wire;
    t_temp;
    close_out;
  end
endmodule
